// *** hw/asf_sample_fifo.sv ***
// Sample buffer with five fill modes, AXI4-Lite register access
//
// Added by the designer: the address map and the AXI4-Lite slave port.
module asf_sample_fifo (
  input  wire logic                      aclk,          // System clock
  input  wire logic                      aresetn,       // Sync reset, low
  input  wire logic [asf_pkg::ASF_AW-1:0] s_axi_awaddr, // Write address
  input  wire logic                      s_axi_awvalid, // Write addr valid
  output logic                           s_axi_awready, // Write addr ready
  input  wire logic [31:0]               s_axi_wdata,   // Write data
  input  wire logic [3:0]                s_axi_wstrb,   // Byte strobes
  input  wire logic                      s_axi_wvalid,  // Write data valid
  output logic                           s_axi_wready,  // Write data ready
  output logic [1:0]                     s_axi_bresp,   // Write response
  output logic                           s_axi_bvalid,  // Response valid
  input  wire logic                      s_axi_bready,  // Response ready
  input  wire logic [asf_pkg::ASF_AW-1:0] s_axi_araddr, // Read address
  input  wire logic                      s_axi_arvalid, // Read addr valid
  output logic                           s_axi_arready, // Read addr ready
  output logic [31:0]                    s_axi_rdata,   // Read data
  output logic [1:0]                     s_axi_rresp,   // Read response
  output logic                           s_axi_rvalid,  // Read data valid
  input  wire logic                      s_axi_rready,  // Read data ready
  input  wire logic                      odr_clk,       // Sample rate pin
  input  wire asf_pkg::asf_sample_s      sample_in,     // New sample set
  input  wire logic                      event_in,      // Latched event
  output logic                           irq_pin_one,   // Interrupt pin 1
  output logic                           irq_pin_two    // Interrupt pin 2
);
  import asf_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic [7:0] asf_idx(input logic [ASF_AW-1:0] a);
    asf_idx = a[ASF_AW-1:2];
  endfunction

  function automatic logic [2:0] asf_next(input logic [2:0] k);
    asf_next = (k == ASF_BYTE_LAST) ? 3'h0 : k + 3'h1;
  endfunction

  // Axis values sit left-justified in their 16-bit pair
  function automatic logic [7:0] asf_byte(input asf_sample_s s,
                                          input logic [2:0]  k);
    logic [15:0] w;
    case (k[2:1])
      2'h0:    w = {s.x, ASF_PAD};
      2'h1:    w = {s.y, ASF_PAD};
      default: w = {s.z, ASF_PAD};
    endcase
    asf_byte = k[0] ? w[15:8] : w[7:0];
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // State

  asf_state_s  st;
  asf_state_s  n;
  asf_sample_s mem [0:ASF_DEPTH-1];
  asf_sample_s mem_q;
  logic        tick;
  logic        ev_routed;
  logic        full;
  logic        bypass;
  logic        thr;
  logic        pop_req;
  logic        pop;
  logic        we;
  logic        ovw;
  logic        ovr_set;
  logic        ar_take;
  logic [7:0]  ridx;
  logic [2:0]  k;
  logic [7:0]  rbyte;

  assign mem_q = mem[st.rd];

  //////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    n       = st;
    pop_req = 1'b0;
    ovr_set = 1'b0;
    k       = 3'h0;
    rbyte   = 8'h00;
    ridx    = asf_idx(s_axi_araddr);
    ar_take = s_axi_arvalid & st.ar_rdy;

    // Two-stage synchronisers on every pin input
    n.odr_s1 = odr_clk;
    n.odr_s2 = st.odr_s1;
    n.odr_s3 = st.odr_s2;
    n.ev_s1  = event_in;
    n.ev_s2  = st.ev_s1;
    n.smp_s1 = sample_in;
    n.smp_s2 = st.smp_s1;

    tick      = st.odr_s2 & ~st.odr_s3;
    ev_routed = st.ev_s2 &
                (st.ctrl[ASF_CTRL_EV_PIN1] | st.ctrl[ASF_CTRL_EV_PIN2]);
    full      = st.count[ASF_CW-1];
    bypass    = (st.mode == ASF_MODE_BYPASS);
    thr       = (st.count >= {1'b0, st.ths});

    // Write channel: address and data taken in either order
    if (s_axi_awvalid && st.aw_rdy) begin
      n.aw_rdy = 1'b0;
      n.aw_idx = asf_idx(s_axi_awaddr);
    end
    if (s_axi_wvalid && st.w_rdy) begin
      n.w_rdy = 1'b0;
      n.wbyte = s_axi_wdata[7:0];
      n.wlane = s_axi_wstrb[0];
    end
    if (!st.aw_rdy && !st.w_rdy && !st.bvalid) begin
      n.bvalid = 1'b1;
      n.bresp  = ASF_OKAY;
      case (st.aw_idx)
        ASF_IDX_CTRL: begin
          if (st.wlane) n.ctrl = st.wbyte;
        end
        ASF_IDX_MODE: begin
          if (st.wlane) n.mode = st.wbyte[ASF_MODE_LSB +: 3];
        end
        ASF_IDX_THS: begin
          if (st.wlane) n.ths = st.wbyte;
        end
        ASF_IDX_SRC, ASF_IDX_SAMPLES, ASF_IDX_STREAM: begin
        end
        default: begin
          if (st.aw_idx < ASF_IDX_OUT0 || st.aw_idx > ASF_IDX_OUT5) begin
            n.bresp = ASF_SLVERR;
          end
        end
      endcase
    end
    if (st.bvalid && s_axi_bready) begin
      n.bvalid = 1'b0;
      n.aw_rdy = 1'b1;
      n.w_rdy  = 1'b1;
    end

    // Read channel; data bytes come from the output set
    if (ar_take) begin
      n.ar_rdy = 1'b0;
      n.rvalid = 1'b1;
      n.rresp  = ASF_OKAY;
      if (ridx >= ASF_IDX_OUT0 && ridx <= ASF_IDX_OUT5) begin
        k     = 3'(ridx - ASF_IDX_OUT0);
        rbyte = asf_byte(st.out, k);
        pop_req = (k == ASF_BYTE_LAST);
        if (st.ctrl[ASF_CTRL_AUTO_INC]) n.sptr = asf_next(k);
      end else begin
        case (ridx)
          ASF_IDX_CTRL:    rbyte = st.ctrl;
          ASF_IDX_MODE:    rbyte = {st.mode, 5'h00};
          ASF_IDX_THS:     rbyte = st.ths;
          ASF_IDX_SRC:     rbyte = {thr, st.ovr, full, 5'h00};
          ASF_IDX_SAMPLES: rbyte = st.count[7:0];
          ASF_IDX_STREAM: begin
            rbyte   = asf_byte(st.out, st.sptr);
            pop_req = (st.sptr == ASF_BYTE_LAST);
            if (st.ctrl[ASF_CTRL_AUTO_INC]) begin
              n.sptr = asf_next(st.sptr);
            end
          end
          default: n.rresp = ASF_SLVERR;
        endcase
      end
      n.rdata = rbyte;
    end
    if (st.rvalid && s_axi_rready) begin
      n.rvalid = 1'b0;
      n.ar_rdy = 1'b1;
    end

    // A set is consumed when its last byte leaves
    pop = pop_req & (st.count != '0) & ~bypass;

    // Fill phase per mode
    case (st.phase)
      ASF_PH_IDLE: begin
        case (st.mode)
          ASF_MODE_STOP: n.phase = ASF_PH_FILL;
          ASF_MODE_CONT, ASF_MODE_C2F: n.phase = ASF_PH_WRAP;
          ASF_MODE_B2C: begin
            if (ev_routed) n.phase = ASF_PH_WRAP;
          end
          default: n.phase = ASF_PH_IDLE;
        endcase
      end
      ASF_PH_WRAP: begin
        if (st.mode == ASF_MODE_C2F && ev_routed) begin
          n.phase = ASF_PH_FILL;
        end else if (st.mode == ASF_MODE_B2C && !st.ev_s2) begin
          n.phase = ASF_PH_HALT;
        end else if (st.mode == ASF_MODE_STOP) begin
          n.phase = ASF_PH_FILL;
        end
      end
      ASF_PH_FILL: begin
        if (tick && full && !pop) begin
          n.phase = ASF_PH_HALT;
          ovr_set = 1'b1;
        end
      end
      ASF_PH_HALT: n.phase = ASF_PH_HALT;
      default:     n.phase = ASF_PH_IDLE;
    endcase

    we  = tick & ~bypass &
          ((st.phase == ASF_PH_WRAP) |
           ((st.phase == ASF_PH_FILL) & (~full | pop)));
    ovw = we & full & ~pop;
    if (ovw) ovr_set = 1'b1;

    if (we) n.wr = st.wr + 8'h01;
    if (pop || ovw) n.rd = st.rd + 8'h01;
    if (we && !ovw && !pop) begin
      n.count = st.count + 9'h001;
    end else if (pop && !(we && !ovw)) begin
      n.count = st.count - 9'h001;
    end

    // Set wins over the clear from a read
    if (ovr_set) begin
      n.ovr = 1'b1;
    end else if (pop) begin
      n.ovr = 1'b0;
    end

    // Output set follows the oldest slot; held when empty
    if (st.count != '0) n.out = mem_q;

    if (bypass) begin
      n.phase = ASF_PH_IDLE;
      n.count = '0;
      n.wr    = '0;
      n.rd    = '0;
      n.ovr   = 1'b0;
    end

    n.irq1 = (full & st.ctrl[ASF_CTRL_FULL_PIN1]) |
             (st.ev_s2 & st.ctrl[ASF_CTRL_EV_PIN1]);
    n.irq2 = (thr & st.ctrl[ASF_CTRL_THR_PIN2]) |
             (st.ev_s2 & st.ctrl[ASF_CTRL_EV_PIN2]);
  end

  //////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st        <= '0;
      st.aw_rdy <= 1'b1;
      st.w_rdy  <= 1'b1;
      st.ar_rdy <= 1'b1;
    end else begin
      st <= n;
    end
  end

  // Each slot keeps the full 14-bit axis values
  always_ff @(posedge aclk) begin
    if (we) mem[st.wr] <= st.smp_s2;
  end

  assign s_axi_awready = st.aw_rdy;
  assign s_axi_wready  = st.w_rdy;
  assign s_axi_bvalid  = st.bvalid;
  assign s_axi_bresp   = st.bresp;
  assign s_axi_arready = st.ar_rdy;
  assign s_axi_rvalid  = st.rvalid;
  assign s_axi_rresp   = st.rresp;
  assign s_axi_rdata   = {24'h000000, st.rdata};
  assign irq_pin_one   = st.irq1;
  assign irq_pin_two   = st.irq2;

  //////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence s_full_tick;
    tick && full && !pop;
  endsequence

  sequence s_read_last;
    ar_take && ridx == ASF_IDX_OUT5 && st.count != '0 && !bypass;
  endsequence

  a_stop_overrun: assert property (
    st.phase == ASF_PH_FILL && !bypass ##0 s_full_tick
    |=> st.phase == ASF_PH_HALT && st.ovr && st.count == ASF_CNT_FULL)
    else $error("stop mode did not halt with overrun");

  a_halt_frozen: assert property (
    st.phase == ASF_PH_HALT && !bypass
    |=> st.wr == $past(st.wr) && st.count <= $past(st.count))
    else $error("halted buffer was written");

  a_bypass_empty: assert property (
    bypass |=> st.count == '0 && st.phase == ASF_PH_IDLE ##1 !st.ovr)
    else $error("bypass did not empty the buffer");

  a_overrun_clear: assert property (
    s_read_last ##0 !ovr_set |=> !st.ovr)
    else $error("overrun survived the first set read");

  a_read_pop: assert property (
    s_read_last ##0 !we
    |=> st.count == $past(st.count) - 9'h001 &&
        st.rd == $past(st.rd) + 8'h01)
    else $error("set read did not release a slot");

  a_wrap_saturate: assert property (
    st.phase == ASF_PH_WRAP && !bypass ##0 s_full_tick
    |=> st.count == ASF_CNT_FULL && st.ovr &&
        st.rd == $past(st.rd) + 8'h01)
    else $error("overwrite did not drop the oldest set");

  a_count_bound: assert property (st.count <= ASF_CNT_FULL)
    else $error("sample count above capacity");

  a_idle_stores: assert property (
    st.phase == ASF_PH_IDLE && tick |=> st.wr == $past(st.wr))
    else $error("sample stored before the event");

  a_c2f_switch: assert property (
    st.phase == ASF_PH_WRAP && st.mode == ASF_MODE_C2F && ev_routed &&
    !bypass |=> st.phase == ASF_PH_FILL)
    else $error("routed event did not switch to stop mode");

  a_unrouted_hold: assert property (
    st.phase == ASF_PH_WRAP && st.mode == ASF_MODE_C2F && !ev_routed
    |=> st.phase != ASF_PH_FILL)
    else $error("unrouted event changed the mode");

  a_read_data: assert property (
    ar_take && ridx == ASF_IDX_OUT0 && !bypass
    |=> s_axi_rvalid && s_axi_rdata[7:0] == {$past(st.out.x[5:0]), ASF_PAD})
    else $error("output byte not taken from oldest set");

  a_stream_wrap: assert property (
    ar_take && ridx == ASF_IDX_STREAM && st.sptr == ASF_BYTE_LAST &&
    st.ctrl[ASF_CTRL_AUTO_INC] |=> st.sptr == 3'h0)
    else $error("stream pointer did not wrap to first byte");

  a_empty_hold: assert property (
    st.count == '0 |=> st.out == $past(st.out))
    else $error("output changed while buffer empty");

  a_thr_pin: assert property (
    st.ctrl[ASF_CTRL_THR_PIN2] && thr |=> irq_pin_two)
    else $error("threshold did not reach pin two");

  a_stream_pop: assert property (
    ar_take && ridx == ASF_IDX_STREAM && st.sptr == ASF_BYTE_LAST &&
    st.count != '0 && !bypass && !we
    |=> st.count == $past(st.count) - 9'h001)
    else $error("stream read of last byte did not release a set");

  a_b2c_halt: assert property (
    st.phase == ASF_PH_WRAP && st.mode == ASF_MODE_B2C && !st.ev_s2
    |=> st.phase == ASF_PH_HALT)
    else $error("cleared event did not stop collection");

  a_full_pin: assert property (
    st.ctrl[ASF_CTRL_FULL_PIN1] && full |=> irq_pin_one)
    else $error("full condition did not reach pin one");

endmodule // asf_sample_fifo

// *** hw/asf_pkg.sv ***
// Constants, types and state layout for the accelerometer sample buffer
//////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - Stop mode fills all 256 slots, one per tick
// - Stop mode: sample when full sets overrun, halts
// - Halted contents kept and readable until bypass
// - Oldest set first, six bytes per set
// - Overrun clears after first set is read
// - Bypass empties buffer and re-arms stop mode
// - Overwrite mode wraps, replacing oldest when full
// - Mode codes 110b, 011b, 100b for overwrite modes
// - Full shows as count MSB in status
// - Host read loads next oldest set to output
// - Overwrite-then-stop switches to stop on event
// - Event switches mode only when routed to pin
// - After switch: full then overrun and halt
// - Bypass-then-overwrite stores nothing before event
// - Threshold interrupt raised when level is reached
// - Bypass-then-overwrite stops when event clears
// - Non-bypass reads of 28h-2Dh give oldest set
// - Each axis stored at 14 bits
// - Drained buffer keeps returning last value
// - Byte reads drain a set only when its last byte (2Dh or stream) is read
// - Auto-increment wraps from 2Dh back to 28h
// - Mode 000b is bypass: cleared and empty
// - Mode 001b selects stop-when-full
// - Threshold flag when count at or above level
// - Count up per tick, down per set read
//////////////////////////////////////////////////////////////////////////////
package asf_pkg;

  localparam int ASF_AW    = 10;
  localparam int ASF_DEPTH = 256;
  localparam int ASF_PW    = 8;
  localparam int ASF_CW    = 9;
  localparam int ASF_XW    = 14;

  // Register indices; byte address is four times the index
  localparam logic [7:0] ASF_IDX_CTRL    = 8'h21;
  localparam logic [7:0] ASF_IDX_MODE    = 8'h25;
  localparam logic [7:0] ASF_IDX_OUT0    = 8'h28;
  localparam logic [7:0] ASF_IDX_OUT5    = 8'h2D;
  localparam logic [7:0] ASF_IDX_THS     = 8'h2E;
  localparam logic [7:0] ASF_IDX_SRC     = 8'h2F;
  localparam logic [7:0] ASF_IDX_SAMPLES = 8'h30;
  localparam logic [7:0] ASF_IDX_STREAM  = 8'h31;

  // Control, mode and status register fields
  localparam int ASF_CTRL_AUTO_INC  = 0;
  localparam int ASF_CTRL_EV_PIN1   = 1;
  localparam int ASF_CTRL_EV_PIN2   = 2;
  localparam int ASF_CTRL_FULL_PIN1 = 3;
  localparam int ASF_CTRL_THR_PIN2  = 4;
  localparam int ASF_MODE_LSB       = 5;
  localparam int ASF_SRC_THR        = 7;
  localparam int ASF_SRC_OVR        = 6;
  localparam int ASF_SRC_FULL       = 5;

  localparam logic [2:0] ASF_MODE_BYPASS = 3'h0;
  localparam logic [2:0] ASF_MODE_STOP   = 3'h1;
  localparam logic [2:0] ASF_MODE_C2F    = 3'h3;
  localparam logic [2:0] ASF_MODE_B2C    = 3'h4;
  localparam logic [2:0] ASF_MODE_CONT   = 3'h6;

  localparam logic [2:0] ASF_BYTE_LAST = 3'h5;
  localparam logic [1:0] ASF_PAD       = 2'h0;
  localparam logic [8:0] ASF_CNT_FULL  = 9'h100;
  localparam logic [1:0] ASF_OKAY      = 2'h0;
  localparam logic [1:0] ASF_SLVERR    = 2'h2;

  typedef struct packed {
    logic [ASF_XW-1:0] x;
    logic [ASF_XW-1:0] y;
    logic [ASF_XW-1:0] z;
  } asf_sample_s;

  typedef enum logic [1:0] {
    ASF_PH_IDLE,
    ASF_PH_WRAP,
    ASF_PH_FILL,
    ASF_PH_HALT
  } asf_phase_e;

  typedef struct packed {
    logic              aw_rdy;
    logic              w_rdy;
    logic [7:0]        aw_idx;
    logic [7:0]        wbyte;
    logic              wlane;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              ar_rdy;
    logic              rvalid;
    logic [1:0]        rresp;
    logic [7:0]        rdata;
    logic [7:0]        ctrl;
    logic [2:0]        mode;
    logic [7:0]        ths;
    asf_phase_e        phase;
    logic [ASF_CW-1:0] count;
    logic [ASF_PW-1:0] wr;
    logic [ASF_PW-1:0] rd;
    logic              ovr;
    asf_sample_s       out;
    logic [2:0]        sptr;
    logic              odr_s1;
    logic              odr_s2;
    logic              odr_s3;
    logic              ev_s1;
    logic              ev_s2;
    asf_sample_s       smp_s1;
    asf_sample_s       smp_s2;
    logic              irq1;
    logic              irq2;
  } asf_state_s;

endpackage

// *** tb/asf_src_model.sv ***
// Sample source model: sample-rate pin, sample sets and event level
module asf_src_model (
  output logic                 odr_clk,   // Sample-rate pin
  output asf_pkg::asf_sample_s sample_in, // Sample set
  output logic                 event_in   // Latched event level
);
  timeunit 1ns;
  timeprecision 1ps;
  import asf_pkg::*;

  int seq;

  // Sample set number i: every axis differs so order faults show
  function automatic asf_sample_s smp(input int i);
    logic [13:0] v;
    v = i[13:0];
    return '{x: v, y: ~v, z: v * 14'h0003 + 14'h0005};
  endfunction

  initial begin
    odr_clk = 1'b0;
    event_in = 1'b0;
    seq = 0;
    sample_in = smp(0);
  end

  // Pin idles low between frames; data moves 4 cycles from each rise
  task automatic ticks(input int n);
    #7;
    repeat (n) begin
      #100 odr_clk = 1'b1;
      #100 odr_clk = 1'b0;
      seq = seq + 1;
      sample_in = smp(seq);
    end
  endtask

  task automatic set_ev(input logic v);
    event_in <= v;
  endtask
endmodule // asf_src_model

// *** tb/tb_top.sv ***
// Self-checking bench for the sample buffer over AXI4-Lite
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import asf_pkg::*;

  localparam logic [9:0] A_CTRL = {ASF_IDX_CTRL, 2'b00};
  localparam logic [9:0] A_MODE = {ASF_IDX_MODE, 2'b00};
  localparam logic [9:0] A_OUT0 = {ASF_IDX_OUT0, 2'b00};
  localparam logic [9:0] A_THS  = {ASF_IDX_THS, 2'b00};
  localparam logic [9:0] A_SRC  = {ASF_IDX_SRC, 2'b00};
  localparam logic [9:0] A_SMP  = {ASF_IDX_SAMPLES, 2'b00};
  localparam logic [9:0] A_STR  = {ASF_IDX_STREAM, 2'b00};

  logic        aclk, aresetn;
  logic [9:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic        awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic        odr_clk, event_in, irq_pin_one, irq_pin_two;
  asf_sample_s sample_in;
  int          err_total, checks_done, base;

  asf_sample_fifo uut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .odr_clk(odr_clk), .sample_in(sample_in),
    .event_in(event_in), .irq_pin_one(irq_pin_one),
    .irq_pin_two(irq_pin_two)
  );

  asf_src_model src (
    .odr_clk(odr_clk), .sample_in(sample_in), .event_in(event_in)
  );

  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // Each channel released at the edge that takes it
  task automatic axw(input logic [9:0] a, input logic [7:0] d,
                     input logic [3:0] s, output logic [1:0] r);
    @(posedge aclk);
    awaddr <= a;
    wdata <= {~d, d, ~d, d};
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        r = bresp;
        bready <= 1'b0;
      end
    end while (!bvalid);
  endtask

  task automatic axr(input logic [9:0] a, output logic [7:0] d,
                     output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        d = rdata[7:0];
        r = rresp;
        rready <= 1'b0;
      end
    end while (!rvalid);
  endtask

  task automatic wreg(input logic [9:0] a, input logic [7:0] d);
    logic [1:0] r;
    axw(a, d, 4'hF, r);
    chk({6'h00, r}, {6'h00, ASF_OKAY});
  endtask

  task automatic wmode(input logic [2:0] m);
    wreg(A_MODE, {m, 5'h00});
  endtask

  task automatic rdc(input logic [9:0] a, input logic [7:0] e,
                     input logic [7:0] m = 8'hFF);
    logic [7:0] d;
    logic [1:0] r;
    axr(a, d, r);
    chk({6'h00, r}, {6'h00, ASF_OKAY});
    chk(d & m, e);
  endtask

  // Output byte k of set i: 16-bit word is axis shifted left by two
  function automatic logic [7:0] eb(input int i, input int k);
    asf_sample_s s;
    logic [13:0] v;
    s = src.smp(i);
    v = (k < 2) ? s.x : (k < 4) ? s.y : s.z;
    return k[0] ? v[13:6] : {v[5:0], 2'b00};
  endfunction

  task automatic rset(input int i);
    for (int k = 0; k < 6; k++) begin
      rdc(A_OUT0 + 10'(4 * k), eb(i, k));
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    logic [7:0] d;
    logic [1:0] r;
    rdc(A_CTRL, 8'h00);
    chk({6'h00, irq_pin_one, irq_pin_two}, 8'h00);
    rdc(A_MODE, 8'h00);
    rdc(A_THS, 8'h00);
    rdc(A_SRC, 8'h80);
    rdc(A_SMP, 8'h00);
    axr(10'h3FC, d, r);
    chk({6'h00, r}, {6'h00, ASF_SLVERR});
    chk(d, 8'h00);
    axw(10'h3FC, 8'h5A, 4'hF, r);
    chk({6'h00, r}, {6'h00, ASF_SLVERR});
    wreg(A_SRC, 8'hFF);
    rdc(A_SRC, 8'h80);
    wreg(A_THS, 8'hA5);
    rdc(A_THS, 8'hA5);
    // Lane 0 strobe low: accepted, register left alone
    axw(A_THS, 8'h3C, 4'hE, r);
    chk({6'h00, r}, {6'h00, ASF_OKAY});
    rdc(A_THS, 8'hA5);
    $display("test reset done");
  endtask

  task automatic t_stop();
    wreg(A_THS, 8'h10);
    wreg(A_CTRL, 8'h09);
    wmode(ASF_MODE_STOP);
    base = src.seq;
    src.ticks(255);
    rdc(A_SMP, 8'hFF);
    rdc(A_SRC, 8'h80);
    src.ticks(1);
    rdc(A_SRC, 8'hA0);
    rdc(A_SMP, 8'h00);
    chk({7'h00, irq_pin_one}, 8'h01);
    src.ticks(3);
    rdc(A_SRC, 8'hE0);
    for (int i = 0; i < 256; i++) begin
      if (i < 128) rset(base + i);
      else for (int k = 0; k < 6; k++) rdc(A_STR, eb(base + i, k));
      if (i == 0) rdc(A_SRC, 8'h80);
    end
    rdc(A_SMP, 8'h00);
    rdc(A_OUT0, eb(base + 255, 0));
    wmode(ASF_MODE_BYPASS);
    rdc(A_SRC, 8'h00);
    wmode(ASF_MODE_STOP);
    src.ticks(2);
    rdc(A_SMP, 8'h02);
    wmode(ASF_MODE_BYPASS);
    rdc(A_SMP, 8'h00);
    $display("test stop done");
  endtask

  task automatic t_cont();
    wreg(A_CTRL, 8'h10);
    wreg(A_THS, 8'h0A);
    wmode(ASF_MODE_CONT);
    base = src.seq;
    src.ticks(9);
    rdc(A_SMP, 8'h09);
    rdc(A_SRC, 8'h00);
    chk({7'h00, irq_pin_two}, 8'h00);
    src.ticks(1);
    rdc(A_SRC, 8'h80);
    chk({7'h00, irq_pin_two}, 8'h01);
    src.ticks(250);
    rdc(A_SMP, 8'h00);
    rdc(A_SRC, 8'hE0);
    rset(base + 4);
    rdc(A_SMP, 8'hFF);
    $display("test overwrite done");
  endtask

  task automatic t_c2f();
    wmode(ASF_MODE_BYPASS);
    wreg(A_CTRL, 8'h00);
    wmode(ASF_MODE_C2F);
    base = src.seq;
    src.set_ev(1'b1);
    src.ticks(260);
    rdc(A_OUT0, eb(base + 4, 0));
    wmode(ASF_MODE_BYPASS);
    src.set_ev(1'b0);
    wreg(A_CTRL, 8'h02);
    wmode(ASF_MODE_C2F);
    base = src.seq;
    src.ticks(20);
    src.set_ev(1'b1);
    src.ticks(236);
    chk({7'h00, irq_pin_one}, 8'h01);
    rdc(A_SRC, 8'hA0);
    src.ticks(4);
    rdc(A_SRC, 8'hE0);
    rdc(A_OUT0, eb(base, 0));
    wmode(ASF_MODE_BYPASS);
    src.set_ev(1'b0);
    $display("test overwrite-then-stop done");
  endtask

  task automatic t_b2c();
    wreg(A_CTRL, 8'h04);
    wmode(ASF_MODE_B2C);
    src.ticks(5);
    rdc(A_SMP, 8'h00);
    src.set_ev(1'b1);
    base = src.seq;
    src.ticks(6);
    rdc(A_SMP, 8'h06);
    chk({7'h00, irq_pin_two}, 8'h01);
    rset(base);
    src.set_ev(1'b0);
    src.ticks(3);
    rdc(A_SMP, 8'h05);
    $display("test bypass-then-overwrite done");
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    err_total = 0;
    checks_done = 0;
    aresetn = 1'b0;
    awaddr = 10'h000;
    araddr = 10'h000;
    wdata = 32'h00000000;
    wstrb = 4'h0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_stop();
    t_cont();
    t_c2f();
    t_b2c();
    finish_test();
  end

  // Whole run is near 13k cycles; this cuts a hang at 40k
  initial begin
    #1000000;
    err_total++;
    finish_test();
  end
endmodule // tb_top
